// ---- common/vmsr_font_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// font selection terms passed to the font decoder
interface vmsr_font_if;
  logic jumperA;
  logic jumperB;
  logic andTerm;
  logic selBit;
  logic [1:0] fontNumber;
  modport regs (output jumperA, output jumperB, output andTerm, output selBit, input fontNumber);
  modport decoder (input jumperA, input jumperB, input andTerm, input selBit, output fontNumber);
endinterface
`default_nettype wire

// ---- common/vmsr_pkg.sv ----
// shared constants for the video mode and status register bank
package vmsr_pkg;

  // host i/o port addresses, ten address bits decoded
  localparam logic [9:0] VMSR_PORT_MODE = 10'h3D8;
  localparam logic [9:0] VMSR_PORT_COLSEL = 10'h3D9;
  localparam logic [9:0] VMSR_PORT_EXT_STAT = 10'h3DA;
  localparam logic [9:0] VMSR_PORT_PEN_CLEAR = 10'h3DB;

  // display_mode_control field positions
  localparam int VMSR_MODE_HIRES_TEXT = 0;
  localparam int VMSR_MODE_GFX320 = 1;
  localparam int VMSR_MODE_MONO = 2;
  localparam int VMSR_MODE_VIDEO_EN = 3;
  localparam int VMSR_MODE_GFX640 = 4;
  localparam int VMSR_MODE_BLINK = 5;

  // display_extended_control field positions
  localparam int VMSR_EXT_FORCE_ON = 0;
  localparam int VMSR_EXT_FONT_SEL = 1;
  localparam int VMSR_EXT_FONT_AND = 2;
  localparam int VMSR_EXT_DIAG_LED = 3;
  localparam int VMSR_EXT_BYPASS = 4;
  localparam int VMSR_EXT_FAST_SCROLL = 5;
  localparam int VMSR_EXT_PAGE_LO = 6;
  localparam int VMSR_EXT_PAGE_HI = 7;

  // colour select field positions
  localparam int VMSR_CSEL_INTENSE = 4;
  localparam int VMSR_CSEL_PALETTE = 5;

  // display_status field positions
  localparam int VMSR_STAT_RETRACE = 0;
  localparam int VMSR_STAT_PEN_TRIG = 1;
  localparam int VMSR_STAT_PEN_SW = 2;
  localparam int VMSR_STAT_VRETRACE = 3;
  localparam int VMSR_STAT_FONT_LO = 4;
  localparam int VMSR_STAT_FONT_HI = 5;

  // values after reset
  localparam logic [5:0] VMSR_MODE_RESET = 6'h00;
  localparam logic [7:0] VMSR_EXT_RESET = 8'h00;
  localparam logic [5:0] VMSR_CSEL_RESET = 6'h00;
  localparam logic [7:0] VMSR_DATA_RESET = 8'h00;

  // rgb colour codes for the two 320x200 palettes
  localparam logic [2:0] VMSR_RGB_BLACK = 3'h0;
  localparam logic [2:0] VMSR_RGB_GREEN = 3'h2;
  localparam logic [2:0] VMSR_RGB_RED = 3'h4;
  localparam logic [2:0] VMSR_RGB_BROWN = 3'h6;
  localparam logic [2:0] VMSR_RGB_CYAN = 3'h3;
  localparam logic [2:0] VMSR_RGB_MAGENTA = 3'h5;
  localparam logic [2:0] VMSR_RGB_WHITE = 3'h7;

  // font number per {jumperA, jumperB, andTerm, selBit}, two bits per entry
  localparam logic [31:0] VMSR_FONT_LUT = 32'hB0E41B4E;

  // graphics submode seen by the pixel path
  typedef enum logic [1:0] {
    VMSR_SUB_TEXT = 2'b00,
    VMSR_SUB_G320 = 2'b01,
    VMSR_SUB_G640 = 2'b10
  } vmsr_sub_t;

endpackage

// ---- logic/vmsr_font_select.sv ----
`timescale 1ns/1ps
`default_nettype none
// font number from the jumpers, the select bit and the attribute and-term
module vmsr_font_select
  import vmsr_pkg::*;
(
  vmsr_font_if.decoder fnt
);
  logic [3:0] lutIndex;

  // table lookup; the table is not monotonic, so no shortcut logic
  always_comb begin
    lutIndex = {fnt.jumperA, fnt.jumperB, fnt.andTerm, fnt.selBit};
    fnt.fontNumber = VMSR_FONT_LUT[{lutIndex, 1'b0} +: 2];
  end
endmodule
`default_nettype wire

// ---- logic/vmsr_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module vmsr_regs
  import vmsr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  // host i/o cycle, one clock per strobe
  input wire logic [9:0] ioAddr,
  input wire logic addrEnable,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioDataIn,
  output logic [7:0] ioDataOut,
  output logic ioDataOe,
  // raster and light pen inputs
  input wire logic hRetrace,
  input wire logic vRetrace,
  input wire logic lightPenStrobe,
  input wire logic lightPenSwitchClosed,
  // board jumpers and per-character attribute
  input wire logic fontJumperA,
  input wire logic fontJumperB,
  input wire logic attributeRedBackgroundBit,
  // pixel code from the graphics shifter
  input wire logic [1:0] pixelCode,
  // decoded controls
  output logic hiResText,
  output logic monochrome,
  output logic blinkEnable,
  output logic [1:0] subMode,
  output logic videoOn,
  output logic diagLed,
  output logic altVideoSelect,
  output logic fastScroll,
  output logic [1:0] textPage,
  output logic [1:0] fontNumber,
  output logic [3:0] pixelColor
);

  // register state
  logic [5:0] modeCtrl_reg;
  logic [5:0] modeCtrl_next;
  logic [7:0] extCtrl_reg;
  logic [7:0] extCtrl_next;
  logic [5:0] colSel_reg;
  logic [5:0] colSel_next;
  logic penTrig_reg;
  logic penTrig_next;
  logic penStrobePrev_reg;
  logic penStrobePrev_next;

  // read path state
  logic [7:0] dataOut_reg;
  logic [7:0] dataOut_next;
  logic dataOe_reg;
  logic dataOe_next;

  // decoded output state
  logic hiResText_reg;
  logic hiResText_next;
  logic monochrome_reg;
  logic monochrome_next;
  logic blinkEnable_reg;
  logic blinkEnable_next;
  vmsr_sub_t subMode_reg;
  vmsr_sub_t subMode_next;
  logic videoOn_reg;
  logic videoOn_next;
  logic diagLed_reg;
  logic diagLed_next;
  logic altVideo_reg;
  logic altVideo_next;
  logic fastScroll_reg;
  logic fastScroll_next;
  logic [1:0] textPage_reg;
  logic [1:0] textPage_next;
  logic [1:0] fontNumber_reg;
  logic [1:0] fontNumber_next;
  logic [3:0] pixelColor_reg;
  logic [3:0] pixelColor_next;

  // decode helpers
  logic portValid;
  logic wrMode;
  logic wrExt;
  logic wrColSel;
  logic wrPenClear;
  logic rdStatus;
  logic penRise;
  logic [7:0] statusByte;

  vmsr_font_if fontBus ();

  // font decoder sees jumpers, select bit and the attribute and-term
  assign fontBus.jumperA = fontJumperA;
  assign fontBus.jumperB = fontJumperB;
  assign fontBus.selBit = extCtrl_reg[VMSR_EXT_FONT_SEL];
  assign fontBus.andTerm = extCtrl_reg[VMSR_EXT_FONT_AND] & attributeRedBackgroundBit;

  vmsr_font_select fontDecoder (
    .fnt(fontBus.decoder)
  );

  // address decode; addrEnable high marks a dma cycle, which is ignored
  always_comb begin
    portValid = !addrEnable;
    wrMode = portValid && ioWrite && (ioAddr == VMSR_PORT_MODE);
    wrColSel = portValid && ioWrite && (ioAddr == VMSR_PORT_COLSEL);
    wrExt = portValid && ioWrite && (ioAddr == VMSR_PORT_EXT_STAT);
    wrPenClear = portValid && ioWrite && (ioAddr == VMSR_PORT_PEN_CLEAR);
    rdStatus = portValid && ioRead && (ioAddr == VMSR_PORT_EXT_STAT);
  end

  // write-only registers; nothing reads them back, software must shadow them
  always_comb begin
    modeCtrl_next = modeCtrl_reg;
    extCtrl_next = extCtrl_reg;
    colSel_next = colSel_reg;
    if (wrMode) begin
      modeCtrl_next = ioDataIn[5:0];
    end
    if (wrExt) begin
      extCtrl_next = ioDataIn;
    end
    if (wrColSel) begin
      colSel_next = ioDataIn[5:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      modeCtrl_reg <= VMSR_MODE_RESET;
      extCtrl_reg <= VMSR_EXT_RESET;
      colSel_reg <= VMSR_CSEL_RESET;
    end else begin
      modeCtrl_reg <= modeCtrl_next;
      extCtrl_reg <= extCtrl_next;
      colSel_reg <= colSel_next;
    end
  end

  // light pen trigger: a rising strobe sets it, a write to 3DB clears it
  always_comb begin
    penStrobePrev_next = lightPenStrobe;
    penRise = lightPenStrobe && !penStrobePrev_reg;
    penTrig_next = penTrig_reg;
    if (wrPenClear) begin
      penTrig_next = 1'b0;
    end
    // a strobe in the clearing cycle is kept, set beats clear
    if (penRise) begin
      penTrig_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      penTrig_reg <= 1'b0;
      penStrobePrev_reg <= 1'b0;
    end else begin
      penTrig_reg <= penTrig_next;
      penStrobePrev_reg <= penStrobePrev_next;
    end
  end

  // status byte built live, so retrace and switch are never stale
  always_comb begin
    statusByte = 8'h00;
    statusByte[VMSR_STAT_RETRACE] = hRetrace | vRetrace;
    statusByte[VMSR_STAT_PEN_TRIG] = penTrig_reg;
    statusByte[VMSR_STAT_PEN_SW] = !lightPenSwitchClosed;
    statusByte[VMSR_STAT_VRETRACE] = vRetrace;
    statusByte[VMSR_STAT_FONT_LO] = fontNumber_reg[0];
    statusByte[VMSR_STAT_FONT_HI] = fontNumber_reg[1];
  end

  // read path; only 3DA answers, other ports leave the bus undriven
  always_comb begin
    dataOut_next = VMSR_DATA_RESET;
    dataOe_next = 1'b0;
    if (rdStatus) begin
      dataOut_next = statusByte;
      dataOe_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dataOut_reg <= VMSR_DATA_RESET;
      dataOe_reg <= 1'b0;
    end else begin
      dataOut_reg <= dataOut_next;
      dataOe_reg <= dataOe_next;
    end
  end

  // mode decode; 640 wins over 320 if software sets both
  always_comb begin
    hiResText_next = modeCtrl_reg[VMSR_MODE_HIRES_TEXT];
    monochrome_next = modeCtrl_reg[VMSR_MODE_MONO];
    blinkEnable_next = modeCtrl_reg[VMSR_MODE_BLINK];
    if (modeCtrl_reg[VMSR_MODE_GFX640]) begin
      subMode_next = VMSR_SUB_G640;
    end else if (modeCtrl_reg[VMSR_MODE_GFX320]) begin
      subMode_next = VMSR_SUB_G320;
    end else begin
      subMode_next = VMSR_SUB_TEXT;
    end
    // force-on bypasses the enable so text updates do not flicker
    videoOn_next = modeCtrl_reg[VMSR_MODE_VIDEO_EN]
                   | extCtrl_reg[VMSR_EXT_FORCE_ON];
    diagLed_next = extCtrl_reg[VMSR_EXT_DIAG_LED];
    altVideo_next = extCtrl_reg[VMSR_EXT_BYPASS];
    // fast scroll only counts in 80x25 text
    fastScroll_next = extCtrl_reg[VMSR_EXT_FAST_SCROLL]
                      && modeCtrl_reg[VMSR_MODE_HIRES_TEXT]
                      && !modeCtrl_reg[VMSR_MODE_GFX320]
                      && !modeCtrl_reg[VMSR_MODE_GFX640];
    if (fastScroll_next) begin
      textPage_next = extCtrl_reg[VMSR_EXT_PAGE_HI:VMSR_EXT_PAGE_LO];
    end else begin
      textPage_next = 2'h0;
    end
    fontNumber_next = fontBus.fontNumber;
  end

  // pixel colour; one cycle of latency, the shifter must allow for it
  always_comb begin
    pixelColor_next = 4'h0;
    unique case (subMode_reg)
      VMSR_SUB_G640: begin
        // background is always black, foreground from colour select
        if (pixelCode[0]) begin
          pixelColor_next = colSel_reg[3:0];
        end
      end
      VMSR_SUB_G320: begin
        if (pixelCode == 2'h0) begin
          pixelColor_next = colSel_reg[3:0];
        end else if (colSel_reg[VMSR_CSEL_PALETTE]) begin
          unique case (pixelCode)
            2'h1: pixelColor_next = {colSel_reg[VMSR_CSEL_INTENSE], VMSR_RGB_CYAN};
            2'h2: pixelColor_next = {colSel_reg[VMSR_CSEL_INTENSE], VMSR_RGB_MAGENTA};
            default: pixelColor_next = {colSel_reg[VMSR_CSEL_INTENSE], VMSR_RGB_WHITE};
          endcase
        end else begin
          unique case (pixelCode)
            2'h1: pixelColor_next = {colSel_reg[VMSR_CSEL_INTENSE], VMSR_RGB_GREEN};
            2'h2: pixelColor_next = {colSel_reg[VMSR_CSEL_INTENSE], VMSR_RGB_RED};
            default: pixelColor_next = {colSel_reg[VMSR_CSEL_INTENSE], VMSR_RGB_BROWN};
          endcase
        end
      end
      VMSR_SUB_TEXT: begin
        pixelColor_next = {1'b0, VMSR_RGB_BLACK};
      end
      default: begin
        pixelColor_next = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hiResText_reg <= 1'b0;
      monochrome_reg <= 1'b0;
      blinkEnable_reg <= 1'b0;
      subMode_reg <= VMSR_SUB_TEXT;
      videoOn_reg <= 1'b0;
      diagLed_reg <= 1'b0;
      altVideo_reg <= 1'b0;
      fastScroll_reg <= 1'b0;
      textPage_reg <= 2'h0;
      fontNumber_reg <= 2'h0;
      pixelColor_reg <= 4'h0;
    end else begin
      hiResText_reg <= hiResText_next;
      monochrome_reg <= monochrome_next;
      blinkEnable_reg <= blinkEnable_next;
      subMode_reg <= subMode_next;
      videoOn_reg <= videoOn_next;
      diagLed_reg <= diagLed_next;
      altVideo_reg <= altVideo_next;
      fastScroll_reg <= fastScroll_next;
      textPage_reg <= textPage_next;
      fontNumber_reg <= fontNumber_next;
      pixelColor_reg <= pixelColor_next;
    end
  end

  // every output comes straight from a flip-flop
  assign ioDataOut = dataOut_reg;
  assign ioDataOe = dataOe_reg;
  assign hiResText = hiResText_reg;
  assign monochrome = monochrome_reg;
  assign blinkEnable = blinkEnable_reg;
  assign subMode = subMode_reg;
  assign videoOn = videoOn_reg;
  assign diagLed = diagLed_reg;
  assign altVideoSelect = altVideo_reg;
  assign fastScroll = fastScroll_reg;
  assign textPage = textPage_reg;
  assign fontNumber = fontNumber_reg;
  assign pixelColor = pixelColor_reg;

endmodule
`default_nettype wire

// ---- testbench/video_mode_status_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module video_mode_status_regs_test
  import vmsr_pkg::*;
;
  logic clk;
  logic reset;
  logic [9:0] ioAddr;
  logic addrEnable, ioWrite, ioRead, ioDataOe, oe;
  logic [7:0] ioDataIn, ioDataOut, rd;
  logic hRetrace, vRetrace, lightPenStrobe, lightPenSwitchClosed;
  logic fontJumperA, fontJumperB, attributeRedBackgroundBit;
  logic [1:0] pixelCode, subMode, textPage, fontNumber;
  logic hiResText, monochrome, blinkEnable, videoOn, diagLed, altVideoSelect, fastScroll;
  logic [3:0] pixelColor;
  int error_cnt;
  int checks_done;
  // expected font per {jumperA, jumperB, andTerm, selBit}, two bits each
  localparam logic [31:0] FONT_EXP = 32'hB0E41B4E;

  vmsr_host_model vmsr_host_model_i (.clk(clk), .ioAddr(ioAddr), .addrEnable(addrEnable),
    .ioWrite(ioWrite), .ioRead(ioRead), .ioDataIn(ioDataIn), .ioDataOut(ioDataOut),
    .ioDataOe(ioDataOe));
  vmsr_regs vmsr_regs_i (.clk(clk), .reset(reset), .ioAddr(ioAddr), .addrEnable(addrEnable),
    .ioWrite(ioWrite), .ioRead(ioRead), .ioDataIn(ioDataIn), .ioDataOut(ioDataOut),
    .ioDataOe(ioDataOe), .hRetrace(hRetrace), .vRetrace(vRetrace),
    .lightPenStrobe(lightPenStrobe), .lightPenSwitchClosed(lightPenSwitchClosed),
    .fontJumperA(fontJumperA), .fontJumperB(fontJumperB),
    .attributeRedBackgroundBit(attributeRedBackgroundBit), .pixelCode(pixelCode),
    .hiResText(hiResText), .monochrome(monochrome), .blinkEnable(blinkEnable),
    .subMode(subMode), .videoOn(videoOn), .diagLed(diagLed), .altVideoSelect(altVideoSelect),
    .fastScroll(fastScroll), .textPage(textPage), .fontNumber(fontNumber),
    .pixelColor(pixelColor));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // write, then let the register and the decoded outputs both land
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    vmsr_host_model_i.io_write(a, d, 1'b0);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rdst(input logic [7:0] exp, input string what);
    vmsr_host_model_i.io_read(VMSR_PORT_EXT_STAT, rd, oe);
    check(what, {7'h00, oe}, 8'h01);
    check(what, rd, exp);
  endtask
  task automatic t_reset;
    check("idle", {hiResText, subMode, videoOn, diagLed, altVideoSelect, fastScroll,
      monochrome}, 8'h00);
  endtask
  // each mode bit alone, then dma and foreign-port writes that must not land
  task automatic t_mode;
    for (int b = 0; b < 6; b++) begin
      wr(VMSR_PORT_MODE, 8'h01 << b);
      check("mode", {2'h0, blinkEnable, subMode[1], videoOn, monochrome, subMode[0],
        hiResText}, 8'h01 << b);
    end
    vmsr_host_model_i.io_write(VMSR_PORT_MODE, 8'h3F, 1'b1);
    wr(10'h3DC, 8'h3F);
    check("refused", {2'h0, blinkEnable, subMode[1], videoOn, monochrome, subMode[0],
      hiResText}, 8'h20);
  endtask
  task automatic t_ext;
    vmsr_host_model_i.set_mode(8'h09);
    for (int p = 0; p < 4; p++) begin
      wr(VMSR_PORT_EXT_STAT, {p[1:0], 6'h20});
      check("page", {5'h00, fastScroll, textPage}, {5'h00, 1'b1, p[1:0]});
    end
    wr(VMSR_PORT_MODE, 8'h00);
    check("40col", {5'h00, fastScroll, textPage}, 8'h00);
    wr(VMSR_PORT_EXT_STAT, 8'h19);
    check("ext", {5'h00, videoOn, diagLed, altVideoSelect}, 8'h07);
    wr(VMSR_PORT_EXT_STAT, 8'h00);
    check("off", {5'h00, videoOn, diagLed, altVideoSelect}, 8'h00);
  endtask
  task automatic t_status;
    for (int i = 0; i < 8; i++) begin
      {hRetrace, vRetrace, lightPenSwitchClosed} = i[2:0];
      rdst({4'h2, vRetrace, !lightPenSwitchClosed, 1'b0, hRetrace | vRetrace},
        "status");
    end
    {hRetrace, vRetrace, lightPenSwitchClosed} = 3'h0;
    vmsr_host_model_i.io_read(VMSR_PORT_MODE, rd, oe);
    check("stray", {oe, rd[6:0]}, 8'h00);
  endtask
  // trigger must stay latched after the strobe drops
  task automatic t_pen;
    lightPenStrobe = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    lightPenStrobe = 1'b0;
    rdst(8'h26, "trigger");
    rdst(8'h26, "latched");
    vmsr_host_model_i.io_write(VMSR_PORT_PEN_CLEAR, 8'hA5, 1'b0);
    rdst(8'h24, "cleared");
  endtask
  task automatic t_font;
    for (int i = 0; i < 16; i++) begin
      {fontJumperA, fontJumperB, attributeRedBackgroundBit} = i[3:1];
      wr(VMSR_PORT_EXT_STAT, {5'h00, 1'b1, i[0], 1'b0});
      check("font", {6'h00, fontNumber}, {6'h00, FONT_EXP[2*i +: 2]});
      rdst({2'h0, FONT_EXP[2*i +: 2], 4'h4}, "font status");
    end
    wr(VMSR_PORT_EXT_STAT, 8'h00);
    check("and term", {6'h00, fontNumber}, 8'h00);
    {fontJumperA, fontJumperB, attributeRedBackgroundBit} = 3'h0;
  endtask
  // pixel code to colour, one cycle per code
  task automatic pix(input logic [7:0] m, input logic [7:0] cs, input logic [15:0] e);
    wr(VMSR_PORT_MODE, m);
    wr(VMSR_PORT_COLSEL, cs);
    for (int c = 0; c < 4; c++) begin
      pixelCode = c[1:0];
      @(posedge clk);
      #1;
      check("pixel", {4'h0, pixelColor}, {4'h0, e[4*c +: 4]});
    end
  endtask
  task automatic t_pixel;
    pix(8'h0A, 8'h09, 16'h6429);
    pix(8'h0A, 8'h35, 16'hFDB5);
    pix(8'h18, 8'h35, 16'h5050);
    pix(8'h08, 8'h35, 16'h0000);
  endtask

  task automatic final_report;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // a hang costs a mismatch; the whole run needs a few hundred cycles
  initial begin
    #100000;
    error_cnt++;
    final_report;
  end

  initial begin
    error_cnt = 0;
    checks_done = 0;
    reset = 1'b1;
    {hRetrace, vRetrace, lightPenStrobe, lightPenSwitchClosed} = 4'h0;
    {fontJumperA, fontJumperB, attributeRedBackgroundBit} = 3'h0;
    pixelCode = 2'h0;
    repeat (4) @(posedge clk);
    #1;
    reset = 1'b0;
    t_reset;
    t_mode;
    t_ext;
    t_status;
    t_pen;
    t_font;
    t_pixel;
    final_report;
  end
endmodule
`default_nettype wire

// ---- testbench/vmsr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// host processor side of the byte i/o bus
module vmsr_host_model
  import vmsr_pkg::*;
(
  input wire logic clk,
  output logic [9:0] ioAddr,
  output logic addrEnable,
  output logic ioWrite,
  output logic ioRead,
  output logic [7:0] ioDataIn,
  input wire logic [7:0] ioDataOut,
  input wire logic ioDataOe
);
  initial begin
    ioAddr = 10'h000;
    addrEnable = 1'b0;
    ioWrite = 1'b0;
    ioRead = 1'b0;
    ioDataIn = 8'h00;
  end
  // one output cycle; released data shows the inverse so stale bytes never look valid
  task automatic io_write(input logic [9:0] a, input logic [7:0] d, input logic dma);
    @(posedge clk);
    #1;
    ioAddr = a;
    addrEnable = dma;
    ioWrite = 1'b1;
    ioDataIn = d;
    @(posedge clk);
    #1;
    ioWrite = 1'b0;
    addrEnable = 1'b0;
    ioDataIn = ~d;
  endtask
  // one input cycle; the answer stands only in the cycle after the strobe
  task automatic io_read(input logic [9:0] a, output logic [7:0] d, output logic oe);
    @(posedge clk);
    #1;
    ioAddr = a;
    ioRead = 1'b1;
    @(posedge clk);
    #1;
    ioRead = 1'b0;
    d = ioDataOut;
    oe = ioDataOe;
  endtask
  // mode change with the picture blanked first
  task automatic set_mode(input logic [7:0] m);
    io_write(VMSR_PORT_MODE, m & 8'hF7, 1'b0);
    io_write(VMSR_PORT_MODE, m, 1'b0);
  endtask
endmodule
`default_nettype wire

// ---- testbench/vmsr_regs_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// port-level watch on the register bank
module vmsr_regs_checker
  import vmsr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] ioAddr,
  input wire logic addrEnable,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioDataIn,
  input wire logic [7:0] ioDataOut,
  input wire logic ioDataOe,
  input wire logic hRetrace,
  input wire logic vRetrace,
  input wire logic lightPenStrobe,
  input wire logic lightPenSwitchClosed,
  input wire logic videoOn,
  input wire logic diagLed,
  input wire logic fastScroll,
  input wire logic [1:0] textPage,
  input wire logic [1:0] fontNumber
);
  logic rdStat;
  logic wrExt;
  logic wrClr;
  // decoded host cycles; dma cycles never count
  assign rdStat = ioRead && !addrEnable && ioAddr == VMSR_PORT_EXT_STAT;
  assign wrExt = ioWrite && !addrEnable && ioAddr == VMSR_PORT_EXT_STAT;
  assign wrClr = ioWrite && !addrEnable && ioAddr == VMSR_PORT_PEN_CLEAR;
  // expected pen trigger, kept apart from the reads so any read spacing is judged
  logic penPrev_reg;
  logic penPrev_next;
  logic penExp_reg;
  logic penExp_next;
  logic ledBit;
  assign ledBit = ioDataIn[3];
  // a rising strobe sets the trigger, a 3DB write clears it, set wins
  always_comb begin
    penPrev_next = lightPenStrobe;
    penExp_next = penExp_reg;
    if (wrClr) begin
      penExp_next = 1'b0;
    end
    if (lightPenStrobe && !penPrev_reg) begin
      penExp_next = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      penPrev_reg <= 1'b0;
      penExp_reg <= 1'b0;
    end else begin
      penPrev_reg <= penPrev_next;
      penExp_reg <= penExp_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_status_answer: assert property (rdStat |=> ioDataOe && ioDataOut[7:6] == 2'h0)
    else $error("status read not answered");
  a_no_stray: assert property (!rdStat |=> !ioDataOe && ioDataOut == 8'h00)
    else $error("data driven without status read");
  a_any_retrace: assert property (rdStat |=> ioDataOut[0] == ($past(hRetrace) | $past(vRetrace)))
    else $error("retrace bit wrong");
  a_vert_retrace: assert property (rdStat |=> ioDataOut[3] == $past(vRetrace))
    else $error("vertical retrace bit wrong");
  a_pen_switch: assert property (rdStat |=> ioDataOut[2] == !$past(lightPenSwitchClosed))
    else $error("pen switch bit wrong");
  a_font_report: assert property (rdStat |=> ioDataOut[5:4] == $past(fontNumber))
    else $error("font number in status wrong");
  a_pen_latch: assert property (rdStat && penExp_reg |=> ioDataOut[1])
    else $error("pen trigger not set");
  a_pen_clear: assert property (rdStat && !penExp_reg |=> !ioDataOut[1])
    else $error("pen trigger not cleared");
  a_force_on: assert property (wrExt && ioDataIn[0] |=> ##1 videoOn)
    else $error("video not forced on");
  a_diag_led: assert property (wrExt |=> ##1 diagLed == $past(ledBit, 2))
    else $error("led does not follow write");
  a_page_gate: assert property (!fastScroll |-> textPage == 2'h0)
    else $error("page set without fast scroll");
endmodule
bind vmsr_regs vmsr_regs_checker vmsr_regs_checker_i (.clk(clk), .reset(reset), .ioAddr(ioAddr),
  .addrEnable(addrEnable), .ioWrite(ioWrite), .ioRead(ioRead), .ioDataIn(ioDataIn),
  .ioDataOut(ioDataOut), .ioDataOe(ioDataOe), .hRetrace(hRetrace), .vRetrace(vRetrace),
  .lightPenStrobe(lightPenStrobe), .lightPenSwitchClosed(lightPenSwitchClosed),
  .videoOn(videoOn), .diagLed(diagLed), .fastScroll(fastScroll), .textPage(textPage),
  .fontNumber(fontNumber));
`default_nettype wire
